// *** logic/picp_top.sv ***
// posted interrupt clear/post register slice behind axi4-lite
// assumes one 20 mhz clock; source requests are one-cycle or level inputs
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/10ps
module picp_top
  import picp_pkg::*;
(
  // clock and reset
  input  wire logic                   CLK_IN,
  input  wire logic                   RST_N_IN,
  // interrupt sources and software post enable
  input  wire logic                   I2C_REQ_IN,
  input  wire logic                   SLEEP_REQ_IN,
  input  wire logic                   SPI_REQ_IN,
  input  wire logic                   GPIO_REQ_IN,
  input  wire logic                   TIMER_REQ_IN,
  input  wire logic                   TOUCH_REQ_IN,
  input  wire logic                   ANALOG_REQ_IN,
  input  wire logic                   VMON_REQ_IN,
  input  wire logic                   SW_INT_ENABLE_IN,
  // pending state and interrupt
  output logic [PICP_SRC_N-1:0]       PENDING_OUT,
  output logic                        IRQ_OUT,
  // axi4-lite write address and data
  input  wire logic [PICP_ADDR_W-1:0] AWADDR_IN,
  input  wire logic                   AWVALID_IN,
  output logic                        AWREADY_OUT,
  input  wire logic [31:0]            WDATA_IN,
  input  wire logic [3:0]             WSTRB_IN,
  input  wire logic                   WVALID_IN,
  output logic                        WREADY_OUT,
  // axi4-lite write response
  output logic [1:0]                  BRESP_OUT,
  output logic                        BVALID_OUT,
  input  wire logic                   BREADY_IN,
  // axi4-lite read
  input  wire logic [PICP_ADDR_W-1:0] ARADDR_IN,
  input  wire logic                   ARVALID_IN,
  output logic                        ARREADY_OUT,
  output logic [31:0]                 RDATA_OUT,
  output logic [1:0]                  RRESP_OUT,
  output logic                        RVALID_OUT,
  input  wire logic                   RREADY_IN
);
  typedef struct packed {
    logic                   aw_got;
    logic [PICP_ADDR_W-1:0] awaddr;
    logic                   w_got;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic [PICP_SRC_N-1:0]  mask;
    logic [PICP_SRC_N-1:0]  pend_out;
    logic                   irq;
    logic                   aw_rdy;
    logic                   w_rdy;
    logic                   ar_rdy;
  } picp_st_t;

  picp_st_t s_q;
  picp_st_t s_d;

  logic [PICP_SRC_N-1:0] src_req;
  logic [PICP_SRC_N-1:0] pend;
  logic [PICP_EV_N-1:0]  ev_flag;
  logic [PICP_EV_N-1:0]  ev_set;
  logic [PICP_EV_N-1:0]  ev_clr;
  logic                  wr_fire;
  logic                  wr_lane0;
  logic                  wr_clr0;
  logic                  wr_stat;
  logic                  wr_mask;
  logic                  rd_fire;

  // source lines placed at their documented bit positions
  always_comb begin
    src_req                 = '0;
    src_req[PICP_BIT_I2C]   = I2C_REQ_IN;
    src_req[PICP_BIT_SLEEP] = SLEEP_REQ_IN;
    src_req[PICP_BIT_SPI]   = SPI_REQ_IN;
    src_req[PICP_BIT_GPIO]  = GPIO_REQ_IN;
    src_req[PICP_BIT_TIMER] = TIMER_REQ_IN;
    src_req[PICP_BIT_TOUCH] = TOUCH_REQ_IN;
    src_req[PICP_BIT_ANLG]  = ANALOG_REQ_IN;
    src_req[PICP_BIT_VMON]  = VMON_REQ_IN;
  end

  // write decode once address and data are both held
  assign wr_fire  = s_q.aw_got && s_q.w_got && !s_q.bvalid;
  assign wr_lane0 = wr_fire && s_q.wstrb[0];
  assign wr_clr0  = wr_lane0 && (s_q.awaddr == PICP_CLR0_ADDR);
  assign wr_stat  = wr_lane0 && (s_q.awaddr == PICP_STAT_ADDR);
  assign wr_mask  = wr_lane0 && (s_q.awaddr == PICP_MASK_ADDR);
  assign rd_fire  = ARVALID_IN && s_q.ar_rdy;

  // per-source pending bits
  genvar gi;
  generate
    for (gi = 0; gi < PICP_SRC_N; gi++) begin : g_pend
      picp_pend_bit u_pend (
        .clk_in   (CLK_IN),
        .rst_n_in (RST_N_IN),
        .src_in   (src_req[gi]),
        .wr_in    (wr_clr0),
        .wdata_in (s_q.wdata[gi]),
        .swen_in  (SW_INT_ENABLE_IN),
        .pend_out (pend[gi])
      );
    end
  endgenerate

  // events: software post and software clear of a pending bit
  assign ev_set[PICP_EV_POST]  = wr_clr0 && SW_INT_ENABLE_IN
                                 && (|s_q.wdata[PICP_SRC_N-1:0]);
  assign ev_set[PICP_EV_CLEAR] = wr_clr0 && !SW_INT_ENABLE_IN
                                 && (|(~s_q.wdata[PICP_SRC_N-1:0] & pend));
  assign ev_clr = wr_stat ? s_q.wdata[PICP_EV_N-1:0] : '0;

  // sticky event flags
  generate
    for (gi = 0; gi < PICP_EV_N; gi++) begin : g_evt
      picp_evt_bit u_evt (
        .clk_in   (CLK_IN),
        .rst_n_in (RST_N_IN),
        .set_in   (ev_set[gi]),
        .clr_in   (ev_clr[gi]),
        .flag_out (ev_flag[gi])
      );
    end
  endgenerate

  // bus handshake, register file and outputs
  always_comb begin
    s_d = s_q;
    // write address and data taken independently
    if (AWVALID_IN && s_q.aw_rdy) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = AWADDR_IN;
    end
    if (WVALID_IN && s_q.w_rdy) begin
      s_d.w_got = 1'b1;
      s_d.wdata = WDATA_IN;
      s_d.wstrb = WSTRB_IN;
    end
    if (wr_fire) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      if (s_q.awaddr == PICP_CLR0_ADDR || s_q.awaddr == PICP_MASK_ADDR
          || s_q.awaddr == PICP_STAT_ADDR || s_q.awaddr == PICP_CTRL_ADDR) begin
        s_d.bresp = PICP_RESP_OK;
      end else begin
        s_d.bresp = PICP_RESP_ERR;
      end
    end
    if (wr_mask) begin
      s_d.mask = s_q.wdata[PICP_SRC_N-1:0];
    end
    if (s_q.bvalid && BREADY_IN) begin
      s_d.bvalid = 1'b0;
    end
    // read path
    if (rd_fire) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = PICP_RESP_OK;
      case (ARADDR_IN)
        PICP_CLR0_ADDR: s_d.rdata = {24'h00_0000, pend};
        PICP_MASK_ADDR: s_d.rdata = {24'h00_0000, s_q.mask};
        PICP_STAT_ADDR: s_d.rdata = {30'h0000_0000, ev_flag};
        PICP_CTRL_ADDR: s_d.rdata = {31'h0000_0000, SW_INT_ENABLE_IN};
        default: begin
          s_d.rdata = PICP_ZERO32;
          s_d.rresp = PICP_RESP_ERR;
        end
      endcase
    end
    if (s_q.rvalid && RREADY_IN) begin
      s_d.rvalid = 1'b0;
    end
    // registered copies for the outputs
    s_d.pend_out = pend;
    s_d.irq      = |(ev_flag & s_q.mask[PICP_EV_N-1:0]);
    // ready flags registered; no new write while a response waits
    s_d.aw_rdy   = !s_d.aw_got && !s_d.bvalid;
    s_d.w_rdy    = !s_d.w_got && !s_d.bvalid;
    s_d.ar_rdy   = !s_d.rvalid;
  end

  // state register
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      s_q          <= '0;
      s_q.mask     <= PICP_MASK_RST;
      s_q.pend_out <= PICP_PEND_RST;
      s_q.aw_rdy   <= 1'b1;
      s_q.w_rdy    <= 1'b1;
      s_q.ar_rdy   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flip-flops
  assign PENDING_OUT = s_q.pend_out;
  assign IRQ_OUT     = s_q.irq;
  assign AWREADY_OUT = s_q.aw_rdy;
  assign WREADY_OUT  = s_q.w_rdy;
  assign BVALID_OUT  = s_q.bvalid;
  assign BRESP_OUT   = s_q.bresp;
  assign ARREADY_OUT = s_q.ar_rdy;
  assign RVALID_OUT  = s_q.rvalid;
  assign RDATA_OUT   = s_q.rdata;
  assign RRESP_OUT   = s_q.rresp;
endmodule

// *** logic/picp_pkg.sv ***
// package for the posted interrupt clear/post block
// assumes a 32-bit axi4-lite bus and eight interrupt sources
package picp_pkg;
  // register map, byte addresses (printed offsets are not all multiples of 4)
  localparam logic [7:0]  PICP_CLR0_INDEX = 8'h00da;
  localparam logic [11:0] PICP_CLR0_ADDR  = {2'b00, PICP_CLR0_INDEX, 2'b00};
  localparam logic [11:0] PICP_MASK_ADDR  = 12'h0000;
  localparam logic [11:0] PICP_STAT_ADDR  = 12'h0004;
  localparam logic [11:0] PICP_CTRL_ADDR  = 12'h0008;
  localparam int          PICP_ADDR_W     = 12;
  localparam int          PICP_SRC_N      = 8;
  // bit positions of the sources
  localparam int PICP_BIT_I2C   = 7;
  localparam int PICP_BIT_SLEEP = 6;
  localparam int PICP_BIT_SPI   = 5;
  localparam int PICP_BIT_GPIO  = 4;
  localparam int PICP_BIT_TIMER = 3;
  localparam int PICP_BIT_TOUCH = 2;
  localparam int PICP_BIT_ANLG  = 1;
  localparam int PICP_BIT_VMON  = 0;
  // reset values
  localparam logic [7:0]  PICP_PEND_RST = 8'h00;
  localparam logic [7:0]  PICP_MASK_RST = 8'h00;
  localparam logic [31:0] PICP_ZERO32   = 32'h0000_0000;
  // axi responses
  localparam logic [1:0]  PICP_RESP_OK  = 2'b00;
  localparam logic [1:0]  PICP_RESP_ERR = 2'b10;
  // status bits of the event register
  localparam int PICP_EV_POST  = 0;
  localparam int PICP_EV_CLEAR = 1;
  localparam int PICP_EV_N     = 2;
endpackage

// *** logic/picp_pend_bit.sv ***
// one pending bit: source set, software clear, software post
// assumes all inputs synchronous to the clock
`timescale 1ns/10ps
module picp_pend_bit
  import picp_pkg::*;
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // controls
  input  wire logic src_in,
  input  wire logic wr_in,
  input  wire logic wdata_in,
  input  wire logic swen_in,
  // state
  output logic      pend_out
);
  typedef struct packed {
    logic pend;
  } picp_pb_t;
  picp_pb_t s_q;
  picp_pb_t s_d;
  // next pending value; a set always beats a clear
  always_comb begin
    s_d = s_q;
    if (wr_in && !wdata_in && !swen_in) begin
      s_d.pend = 1'b0;
    end
    if (src_in || (wr_in && wdata_in && swen_in)) begin
      s_d.pend = 1'b1;
    end
  end
  // state register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign pend_out = s_q.pend;
endmodule

// *** logic/picp_evt_bit.sv ***
// sticky event flag, cleared by writing one, set beats clear
// assumes synchronous inputs
`timescale 1ns/10ps
module picp_evt_bit (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // controls
  input  wire logic set_in,
  input  wire logic clr_in,
  // state
  output logic      flag_out
);
  typedef struct packed {
    logic flag;
  } picp_eb_t;
  picp_eb_t s_q;
  picp_eb_t s_d;
  // set wins over a same-cycle clear
  always_comb begin
    s_d = s_q;
    if (clr_in) begin
      s_d.flag = 1'b0;
    end
    if (set_in) begin
      s_d.flag = 1'b1;
    end
  end
  // state register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign flag_out = s_q.flag;
endmodule

// *** sim/picp_assertions.sv ***
// checker for the posted interrupt clear/post slice
// assumes it is bound to picp_top and sees only its ports
`timescale 1ns/10ps
module picp_chk
  import picp_pkg::*;
(
  // clock and reset
  input wire logic                  CLK_IN,
  input wire logic                  RST_N_IN,
  // sources and pending state
  input wire logic                  I2C_REQ_IN, SLEEP_REQ_IN, SPI_REQ_IN,
  input wire logic                  GPIO_REQ_IN, TIMER_REQ_IN, TOUCH_REQ_IN,
  input wire logic                  ANALOG_REQ_IN, VMON_REQ_IN,
  input wire logic [PICP_SRC_N-1:0] PENDING_OUT,
  // bus handshakes
  input wire logic                  AWREADY_OUT, WREADY_OUT, BVALID_OUT,
  input wire logic                  BREADY_IN, ARVALID_IN, ARREADY_OUT,
  input wire logic                  RVALID_OUT,
  input wire logic [1:0]            BRESP_OUT, RRESP_OUT,
  input wire logic [31:0]           RDATA_OUT
);
  logic [7:0] src;
  // requests in register bit order
  assign src = {I2C_REQ_IN, SLEEP_REQ_IN, SPI_REQ_IN, GPIO_REQ_IN,
                TIMER_REQ_IN, TOUCH_REQ_IN, ANALOG_REQ_IN, VMON_REQ_IN};
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // pending state
  chk_reset_clean: assert property
    ($rose(RST_N_IN) |-> PENDING_OUT == 8'h00)
    else $error("pending bit set right after reset");
  chk_src_sets: assert property
    ((|src) |-> ##2 (&(PENDING_OUT | ~$past(src, 2))))
    else $error("source request not shown in its bit");
  chk_pend_fall: assert property
    (|($past(PENDING_OUT) & ~PENDING_OUT) |->
     $past(BVALID_OUT) || $past(BVALID_OUT, 2))
    else $error("pending bit fell without a write");
  // bus handshakes
  chk_b_hold: assert property
    (BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT))
    else $error("write response dropped before taken");
  chk_b_blocks: assert property
    (BVALID_OUT |-> !AWREADY_OUT && !WREADY_OUT)
    else $error("write accepted while response pending");
  chk_r_blocks: assert property (RVALID_OUT |-> !ARREADY_OUT)
    else $error("read accepted while data pending");
  chk_r_answer: assert property (ARVALID_IN && ARREADY_OUT |=> RVALID_OUT)
    else $error("read data late");
  chk_err_zero: assert property
    (RVALID_OUT && RRESP_OUT == PICP_RESP_ERR |-> RDATA_OUT == 32'h0000_0000)
    else $error("error read carries data");
endmodule
bind picp_top picp_chk picp_chk_inst (
  .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .I2C_REQ_IN(I2C_REQ_IN),
  .SLEEP_REQ_IN(SLEEP_REQ_IN), .SPI_REQ_IN(SPI_REQ_IN),
  .GPIO_REQ_IN(GPIO_REQ_IN), .TIMER_REQ_IN(TIMER_REQ_IN),
  .TOUCH_REQ_IN(TOUCH_REQ_IN), .ANALOG_REQ_IN(ANALOG_REQ_IN),
  .VMON_REQ_IN(VMON_REQ_IN), .PENDING_OUT(PENDING_OUT),
  .AWREADY_OUT(AWREADY_OUT), .WREADY_OUT(WREADY_OUT),
  .BVALID_OUT(BVALID_OUT), .BREADY_IN(BREADY_IN), .ARVALID_IN(ARVALID_IN),
  .ARREADY_OUT(ARREADY_OUT), .RVALID_OUT(RVALID_OUT),
  .BRESP_OUT(BRESP_OUT), .RRESP_OUT(RRESP_OUT), .RDATA_OUT(RDATA_OUT)
);

// *** sim/posted_interrupt_clear_post_tb.sv ***
// self-checking bench for the posted interrupt clear/post slice
// assumes picp_top with its checker bound; bench is the bus master
`timescale 1ns/10ps
module posted_interrupt_clear_post_tb
  import picp_pkg::*;
;
  typedef struct {logic [7:0] pre; logic sw; logic [7:0] wd, ex;} picp_row_t;
  logic        clk = 1'b0, rst_n = 1'b0, swen = 1'b0;
  logic [7:0]  req = 8'h00;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic        aw = 1'b0, w = 1'b0, bready = 1'b0, ar = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp, bs, rs;
  logic [31:0] rdata, d;
  logic [7:0]  pend;
  int          fails = 0, samples_checked = 0;
  // preset pending, post enable, written byte, expected pending
  picp_row_t rows [6] = '{'{8'hff, 1'b0, 8'h0f, 8'h0f},
    '{8'h0f, 1'b0, 8'h3c, 8'h0c}, '{8'ha5, 1'b1, 8'h00, 8'ha5},
    '{8'h00, 1'b1, 8'h81, 8'h81}, '{8'h50, 1'b1, 8'h0a, 8'h5a},
    '{8'h33, 1'b0, 8'hff, 8'h33}};
  // clock
  always #25 clk = ~clk;
  picp_top picp_top_inst (
    .CLK_IN(clk), .RST_N_IN(rst_n), .I2C_REQ_IN(req[7]),
    .SLEEP_REQ_IN(req[6]), .SPI_REQ_IN(req[5]), .GPIO_REQ_IN(req[4]),
    .TIMER_REQ_IN(req[3]), .TOUCH_REQ_IN(req[2]), .ANALOG_REQ_IN(req[1]),
    .VMON_REQ_IN(req[0]), .SW_INT_ENABLE_IN(swen), .PENDING_OUT(pend),
    .IRQ_OUT(irq), .AWADDR_IN(awaddr), .AWVALID_IN(aw),
    .AWREADY_OUT(awready), .WDATA_IN(wdata), .WSTRB_IN(4'hf),
    .WVALID_IN(w), .WREADY_OUT(wready), .BRESP_OUT(bresp),
    .BVALID_OUT(bvalid), .BREADY_IN(bready), .ARADDR_IN(araddr),
    .ARVALID_IN(ar), .ARREADY_OUT(arready), .RDATA_OUT(rdata),
    .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(1'b1));
  // value compare
  task automatic chk(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // write; response accepted lag edges late
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input int lag);
    awaddr <= a;
    wdata <= v;
    aw <= 1'b1;
    w <= 1'b1;
    bready <= (lag == 0);
    do begin
      @(posedge clk);
      lag--;
      if (awready) aw <= 1'b0;
      if (wready) w <= 1'b0;
      if (lag <= 0) bready <= 1'b1;
    end while (!(bvalid === 1'b1 && bready));
    bs = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask
  // read into d and rs
  task automatic rd(input logic [11:0] a);
    araddr <= a;
    ar <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) ar <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    rs = rresp;
    @(posedge clk);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(PICP_CLR0_ADDR);
    chk("clear reg", 32'h0000_0000, d);
    rd(PICP_MASK_ADDR);
    chk("mask reg", 32'h0000_0000, d);
    foreach (rows[k]) begin
      req <= rows[k].pre;
      @(posedge clk);
      req <= 8'h00;
      swen <= rows[k].sw;
      wr(PICP_CLR0_ADDR, 32'(rows[k].wd), 2 * (k % 3));
      rd(PICP_CLR0_ADDR);
      chk("clear reg", 32'(rows[k].ex), d);
      chk("pending", 32'(rows[k].ex), 32'(pend));
      swen <= 1'b0;
      wr(PICP_CLR0_ADDR, 32'h0000_0000, 0);
    end
    // one source at a time lands in its own bit
    for (int i = 0; i < 8; i++) begin
      req <= 8'h01 << i;
      @(posedge clk);
      req <= 8'h00;
      rd(PICP_CLR0_ADDR);
      chk("source bit", 32'h0000_0001 << i, d);
      wr(PICP_CLR0_ADDR, 32'h0000_0000, 0);
    end
    // unmapped place
    rd(12'h100);
    chk("bad read", 32'(PICP_RESP_ERR), 32'(rs));
    wr(12'h100, 32'h0000_0000, 4);
    chk("bad write", 32'(PICP_RESP_ERR), 32'(bs));
    // interrupt raise, clear, mask
    wr(PICP_STAT_ADDR, 32'h0000_0003, 0);
    wr(PICP_MASK_ADDR, 32'h0000_0001, 0);
    swen <= 1'b1;
    wr(PICP_CLR0_ADDR, 32'h0000_0010, 0);
    chk("irq", 32'h0000_0001, 32'(irq));
    wr(PICP_STAT_ADDR, 32'h0000_0001, 0);
    chk("irq", 32'h0000_0000, 32'(irq));
    wr(PICP_MASK_ADDR, 32'h0000_0000, 0);
    wr(PICP_CLR0_ADDR, 32'h0000_0020, 0);
    chk("irq", 32'h0000_0000, 32'(irq));
    rd(PICP_STAT_ADDR);
    chk("status", 32'h0000_0001, d);
    // reset in mid-run drops pending state
    req <= 8'hff;
    @(posedge clk);
    req <= 8'h00;
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("pending", 32'h0000_0000, 32'(pend));
    results();
  end
  // watchdog
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    results();
  end
endmodule
